//--- design/pwm_analog_output_pkg.sv
// Constants, register map and types for the PWM analogue output generator
package pwm_analog_output_pkg;

  // Clock and base tick rates
  localparam int unsigned CLOCK_HZ      = 40000000;
  localparam int unsigned BASE_TICK_HZ  = 921600;
  localparam int unsigned ACC_WIDTH     = 26;
  localparam logic [25:0] TICK_STEP     = 26'(BASE_TICK_HZ);
  localparam logic [25:0] TICK_MODULUS  = 26'(CLOCK_HZ);

  // Register bus geometry
  localparam int unsigned ADDR_WIDTH    = 8;
  localparam int unsigned DATA_WIDTH    = 32;
  localparam int unsigned LEVEL_WIDTH   = 16;

  // Register byte offsets
  localparam logic [7:0]  REG_LEVEL      = 8'h00;
  localparam logic [7:0]  REG_RESOLUTION = 8'h04;
  localparam logic [7:0]  REG_FUNCTION   = 8'h08;
  localparam logic [7:0]  REG_STATUS     = 8'h0c;
  localparam logic [7:0]  REG_MASK       = 8'h10;
  localparam logic [7:0]  REG_STATE      = 8'h14;
  localparam logic [7:0]  REG_COUNT      = 8'h18;
  localparam logic [7:0]  REG_PERIODS    = 8'h1c;

  // Values after reset
  localparam logic [15:0] LEVEL_RESET      = 16'h0000;
  localparam logic [4:0]  RESOLUTION_RESET = 5'h08;
  localparam logic [3:0]  FUNCTION_RESET   = 4'h1;
  localparam logic [2:0]  MASK_RESET       = 3'h0;

  // Field values and limits
  localparam logic [3:0]  FUNCTION_PWM     = 4'h7;
  localparam logic [4:0]  RESOLUTION_MIN   = 5'h01;
  localparam logic [4:0]  RESOLUTION_MAX   = 5'h10;

  // Status bit positions
  localparam int unsigned STATUS_WIDTH     = 3;
  localparam int unsigned ST_LEVEL_ERROR   = 0;
  localparam int unsigned ST_RES_ERROR     = 1;
  localparam int unsigned ST_PERIOD_END    = 2;

  // State register bit positions
  localparam int unsigned STATE_ENABLED    = 0;
  localparam int unsigned STATE_OUTPUT     = 1;
  localparam int unsigned STATE_RANGE_OK   = 2;

  typedef enum logic [1:0] {
    GEN_IDLE = 2'b00,
    GEN_HIGH = 2'b01,
    GEN_LOW  = 2'b10
  } gen_state_type;

endpackage

//--- design/tick_link_if.sv
// Interface carrying the base tick from the divider to the generator
`timescale 1ns/1ps
`default_nettype none
interface tick_link_if;
  logic tick;
  modport source (output tick);
  modport sink   (input  tick);
endinterface
`default_nettype wire

//--- design/pwm_tick_divider.sv
// Fractional divider making the base tick from the system clock
`timescale 1ns/1ps
`default_nettype none
module pwm_tick_divider
  import pwm_analog_output_pkg::*;
(
  input  wire logic   clock,
  input  wire logic   rst_b,
  tick_link_if.source link
);

  logic [25:0] acc;
  logic [26:0] sum;
  logic        wrap;

  // Phase accumulator: one tick per modulus crossing, average rate exact
  assign sum  = {1'b0, acc} + {1'b0, TICK_STEP};
  assign wrap = sum >= {1'b0, TICK_MODULUS};

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      acc       <= 26'h0000000;
      link.tick <= 1'b0;
    end else begin
      acc       <= wrap ? 26'(sum - {1'b0, TICK_MODULUS}) : sum[25:0];
      link.tick <= wrap;
    end
  end

endmodule
`default_nettype wire

//--- design/pwm_analog_output.sv
// PWM analogue output generator with register port and interrupt
//
// Behaviour
// - Level accepts 0 to 65535; filtered mean spans 0.00 to 5.00 V.
// - Resolution comes from the resolution register, 1 to 16 bits.
// - At n bits the usable level span is 0 to 2^n minus 1.
// - Repetition is 460800 Hz at 1 bit, halving per bit, 14.06 Hz at 16.
// - Output active only while function select holds 7.
// - A level write beyond the current span flags an error.
// - Level writes are accepted in every operating mode.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pwm_analog_output
  import pwm_analog_output_pkg::*;
#(
  parameter int unsigned LEVEL_BITS = LEVEL_WIDTH
)
(
  input  wire logic                  CLOCK,
  input  wire logic                  RST_B,
  input  wire logic [ADDR_WIDTH-1:0] ADDR,
  input  wire logic [DATA_WIDTH-1:0] WDATA,
  input  wire logic                  WR,
  input  wire logic                  RD,
  output var  logic [DATA_WIDTH-1:0] RDATA,
  output var  logic                  ANALOG_OUT,
  output var  logic                  IRQ
);

  // Base tick from the fractional divider
  tick_link_if tick_link ();

  pwm_tick_divider u_divider (
    .clock (CLOCK),
    .rst_b (RST_B),
    .link  (tick_link.source)
  );

  logic                    tick;
  assign tick = tick_link.tick;

  // Software registers
  logic [LEVEL_BITS-1:0]   analog_out_level;
  logic [4:0]              pwm_resolution_bits;
  logic [3:0]              timer2_function_select;
  logic [STATUS_WIDTH-1:0] status;
  logic [STATUS_WIDTH-1:0] mask;

  // Generator state
  gen_state_type           state;
  gen_state_type           next_state;
  logic [LEVEL_BITS-1:0]   count;
  logic [LEVEL_BITS-1:0]   next_count;
  logic [LEVEL_BITS-1:0]   shadow_level;
  logic [LEVEL_BITS-1:0]   next_shadow_level;
  logic [15:0]             periods;
  logic [STATUS_WIDTH-1:0] next_status;
  logic [DATA_WIDTH-1:0]   read_value;

  // Address decode
  logic wr_level;
  logic wr_resolution;
  logic wr_function;
  logic wr_status;
  logic wr_mask;

  assign wr_level      = WR && (ADDR == REG_LEVEL);
  assign wr_resolution = WR && (ADDR == REG_RESOLUTION);
  assign wr_function   = WR && (ADDR == REG_FUNCTION);
  assign wr_status     = WR && (ADDR == REG_STATUS);
  assign wr_mask       = WR && (ADDR == REG_MASK);

  // Span mask: bit i set when i is below the resolution, i.e. 2^n - 1
  logic [LEVEL_BITS-1:0] span_mask;

  genvar bit_index;
  generate
    for (bit_index = 0; bit_index < LEVEL_BITS; bit_index++) begin : g_span
      assign span_mask[bit_index] = 5'(bit_index) < pwm_resolution_bits;
    end
  endgenerate

  // Range checks on incoming writes and on the stored level
  logic [LEVEL_BITS-1:0] write_level;
  logic [4:0]            write_resolution;
  logic                  level_in_range;
  logic                  resolution_valid;
  logic                  stored_in_range;

  assign write_level      = WDATA[LEVEL_BITS-1:0];
  assign write_resolution = WDATA[4:0];
  assign level_in_range   = ((write_level & ~span_mask) == '0)
                            && (WDATA[DATA_WIDTH-1:LEVEL_BITS] == '0);
  assign resolution_valid = (write_resolution >= RESOLUTION_MIN)
                            && (write_resolution <= RESOLUTION_MAX)
                            && (WDATA[DATA_WIDTH-1:5] == '0);
  assign stored_in_range  = (analog_out_level & ~span_mask) == '0;

  // Events
  logic ev_level_error;
  logic ev_res_error;
  logic ev_period_end;
  logic enabled;
  logic period_last;
  logic leave_high;
  logic [LEVEL_BITS-1:0] count_inc;

  assign ev_level_error = wr_level && !level_in_range;
  assign ev_res_error   = wr_resolution && !resolution_valid;
  assign enabled        = timer2_function_select == FUNCTION_PWM;
  assign period_last    = count >= span_mask;
  assign count_inc      = count + LEVEL_BITS'(1);
  assign leave_high     = count_inc >= shadow_level;
  assign ev_period_end  = tick && (state != GEN_IDLE) && enabled && period_last;

  // Level register: any mode, value kept even when out of span
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      analog_out_level <= LEVEL_RESET;
    end else if (wr_level) begin
      analog_out_level <= write_level;
    end
  end

  // Resolution register: out-of-range writes leave the old value
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      pwm_resolution_bits <= RESOLUTION_RESET;
    end else if (wr_resolution && resolution_valid) begin
      pwm_resolution_bits <= write_resolution;
    end
  end

  // Function select register
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      timer2_function_select <= FUNCTION_RESET;
    end else if (wr_function) begin
      timer2_function_select <= WDATA[3:0];
    end
  end

  // Interrupt mask register
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      mask <= MASK_RESET;
    end else if (wr_mask) begin
      mask <= WDATA[STATUS_WIDTH-1:0];
    end
  end

  // Sticky status: write one clears, a same-cycle event wins
  logic [STATUS_WIDTH-1:0] status_clear;
  logic [STATUS_WIDTH-1:0] status_set;

  assign status_clear = wr_status ? WDATA[STATUS_WIDTH-1:0] : '0;
  assign status_set   = {ev_period_end, ev_res_error, ev_level_error};
  assign next_status  = (status & ~status_clear) | status_set;

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      status <= '0;
      IRQ    <= 1'b0;
    end else begin
      status <= next_status;
      IRQ    <= |(next_status & mask);
    end
  end

  // Generator state machine
  always_comb begin
    next_state        = state;
    next_count        = count;
    next_shadow_level = shadow_level;
    case (state)
      GEN_IDLE: begin
        next_count = '0;
        if (enabled) begin
          next_shadow_level = analog_out_level;
          next_state        = (analog_out_level != '0) ? GEN_HIGH : GEN_LOW;
        end
      end
      GEN_HIGH, GEN_LOW: begin
        if (!enabled) begin
          next_state = GEN_IDLE;
          next_count = '0;
        end else if (tick) begin
          if (period_last) begin
            // New period: take the latest level so edits never cut a pulse
            next_count        = '0;
            next_shadow_level = analog_out_level;
            next_state        = (analog_out_level != '0) ? GEN_HIGH : GEN_LOW;
          end else begin
            next_count = count_inc;
            if (state == GEN_HIGH && leave_high) begin
              next_state = GEN_LOW;
            end
          end
        end
      end
      default: begin
        next_state = GEN_IDLE;
        next_count = '0;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      state        <= GEN_IDLE;
      count        <= '0;
      shadow_level <= LEVEL_RESET;
      ANALOG_OUT   <= 1'b0;
    end else begin
      state        <= next_state;
      count        <= next_count;
      shadow_level <= next_shadow_level;
      ANALOG_OUT   <= next_state == GEN_HIGH;
    end
  end

  // Completed period counter, wraps silently
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      periods <= 16'h0000;
    end else if (ev_period_end) begin
      periods <= periods + 16'h0001;
    end
  end

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    read_value = '0;
    case (ADDR)
      REG_LEVEL:      read_value[LEVEL_BITS-1:0]   = analog_out_level;
      REG_RESOLUTION: read_value[4:0]              = pwm_resolution_bits;
      REG_FUNCTION:   read_value[3:0]              = timer2_function_select;
      REG_STATUS:     read_value[STATUS_WIDTH-1:0] = status;
      REG_MASK:       read_value[STATUS_WIDTH-1:0] = mask;
      REG_STATE: begin
        read_value[STATE_ENABLED]  = enabled;
        read_value[STATE_OUTPUT]   = state == GEN_HIGH;
        read_value[STATE_RANGE_OK] = stored_in_range;
      end
      REG_COUNT:      read_value[LEVEL_BITS-1:0]   = count;
      REG_PERIODS:    read_value[15:0]             = periods;
      default:        read_value                   = '0;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      RDATA <= '0;
    end else begin
      RDATA <= RD ? read_value : '0;
    end
  end

endmodule
`default_nettype wire

//--- verification/pwm_analog_output_props.sv
// Port checker for the PWM analogue output generator
`timescale 1ns/1ps
`default_nettype none
module pwm_analog_output_props
  import pwm_analog_output_pkg::*;
(
  input wire logic                  CLOCK,
  input wire logic                  RST_B,
  input wire logic [ADDR_WIDTH-1:0] ADDR,
  input wire logic [DATA_WIDTH-1:0] WDATA,
  input wire logic                  WR,
  input wire logic                  RD,
  input wire logic [DATA_WIDTH-1:0] RDATA,
  input wire logic                  ANALOG_OUT,
  input wire logic                  IRQ
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  sequence s_wr(logic [7:0] a);
    WR && ADDR == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    RD && ADDR == a;
  endsequence
  a_rdata_idle_zero: assert property (!RD |=> RDATA == '0)
    else $error("read data not zero outside a read");
  a_level_width: assert property (s_rd(REG_LEVEL) |=> RDATA[31:16] == 16'h0000)
    else $error("level read has upper bits set");
  a_level_readback: assert property (s_wr(REG_LEVEL) ##2 s_rd(REG_LEVEL)
    |=> RDATA == ($past(WDATA, 3) & 32'h0000ffff))
    else $error("level read differs from write");
  a_res_in_span: assert property (s_wr(REG_RESOLUTION) ##2 s_rd(REG_RESOLUTION)
    |=> RDATA >= 32'h1 && RDATA <= 32'h10)
    else $error("resolution outside one to sixteen");
  a_func_readback: assert property (s_wr(REG_FUNCTION) ##2 s_rd(REG_FUNCTION)
    |=> RDATA == ($past(WDATA, 3) & 32'h0000000f))
    else $error("function select read differs");
  a_disable_pin_low: assert property (WR && ADDR == REG_FUNCTION
    && WDATA[31:4] == 28'h0 && WDATA[3:0] != FUNCTION_PWM |-> ##2 !ANALOG_OUT)
    else $error("pin not low after disable");
  // A rise straight after enabling may meet a tick at once, so only period starts count
  a_high_min_tick: assert property ($rose(ANALOG_OUT)
    && !$past(WR && ADDR == REG_FUNCTION, 2) |=> ANALOG_OUT [*8])
    else $error("high phase shorter than a tick");
  a_mask_gate_irq: assert property (WR && ADDR == REG_MASK
    && WDATA == 32'h0 |-> ##2 !IRQ)
    else $error("interrupt high with mask clear");
endmodule
bind pwm_analog_output pwm_analog_output_props u_props (
  .CLOCK(CLOCK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .ANALOG_OUT(ANALOG_OUT), .IRQ(IRQ)
);
`default_nettype wire

//--- verification/pwm_analog_output_tb.sv
// Register-driven testbench for the PWM analogue output generator
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module pwm_analog_output_tb
  import pwm_analog_output_pkg::*;
;
  logic        clock;
  logic        rst_b;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        analog_out;
  logic        irq;
  logic [31:0] v;
  logic [31:0] bad [3];
  int          err_count;
  int          cmp_count;
  int          n;
  int          hi;
  int          per;
  int          ep;

  pwm_analog_output uut (
    .CLOCK(clock), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .ANALOG_OUT(analog_out), .IRQ(irq)
  );

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic end_sim;
    if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic chk_rd(input string s, input logic [7:0] a, input logic [31:0] m, e);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    `CHK(s, e, rdata & m)
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Clocks from one rise of the pin to the next, and how many of them were high
  task automatic meas(output int h, output int p);
    logic q;
    @(posedge analog_out);
    #1;
    h = 1;
    p = 1;
    q = 1'b1;
    forever begin
      @(posedge clock);
      #1;
      if (analog_out === 1'b1 && q === 1'b0) break;
      q = analog_out;
      p++;
      if (q === 1'b1) h++;
    end
  endtask

  task automatic count_hi(input int c, output int h);
    h = 0;
    repeat (c) begin
      @(posedge clock);
      #1;
      if (analog_out !== 1'b0) h++;
    end
  endtask

  initial begin
    repeat (40000) @(posedge clock);
    err_count++;
    end_sim();
  end

  initial begin
    err_count = 0;
    cmp_count = 0;
    rst_b = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    bad = '{32'h0, 32'h11, 32'h21};
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    chk_rd("level", REG_LEVEL, 32'hffffffff, 32'h0);
    chk_rd("res", REG_RESOLUTION, 32'hffffffff, 32'h8);
    chk_rd("func", REG_FUNCTION, 32'hffffffff, 32'h1);
    chk_rd("mask", REG_MASK, 32'hffffffff, 32'h0);
    chk_rd("status", REG_STATUS, 32'h3, 32'h0);
    chk_rd("unmapped", 8'h20, 32'hffffffff, 32'h0);
    `CHK("pin off", 1'b0, analog_out)
    foreach (bad[i]) begin
      wr_reg(REG_RESOLUTION, bad[i]);
      chk_rd("res kept", REG_RESOLUTION, 32'hffffffff, 32'h8);
      chk_rd("res flag", REG_STATUS, 32'h2, 32'h2);
      wr_reg(REG_STATUS, 32'h2);
      chk_rd("res clr", REG_STATUS, 32'h2, 32'h0);
    end
    // Top of each span is accepted, one above it is flagged for 1 to 15 bits
    for (n = 1; n <= 16; n++) begin
      wr_reg(REG_RESOLUTION, 32'(n));
      chk_rd("res", REG_RESOLUTION, 32'hffffffff, 32'(n));
      wr_reg(REG_LEVEL, (32'h1 << n) - 32'h1);
      chk_rd("in span", REG_STATUS, 32'h1, 32'h0);
      if (n < 16) begin
        wr_reg(REG_LEVEL, 32'h1 << n);
        chk_rd("out span", REG_STATUS, 32'h1, 32'h1);
        wr_reg(REG_STATUS, 32'h1);
      end
    end
    wr_reg(REG_RESOLUTION, 32'h1);
    wr_reg(REG_LEVEL, 32'h2);
    wr_reg(REG_MASK, 32'h1);
    repeat (2) @(posedge clock);
    #1;
    `CHK("irq on", 1'b1, irq)
    wr_reg(REG_MASK, 32'h0);
    repeat (2) @(posedge clock);
    #1;
    `CHK("irq masked", 1'b0, irq)
    wr_reg(REG_STATUS, 32'h7);
    wr_reg(REG_FUNCTION, 32'(FUNCTION_PWM));
    chk_rd("func", REG_FUNCTION, 32'hffffffff, 32'h7);
    chk_rd("enabled", REG_STATE, 32'h1, 32'h1);
    for (n = 1; n <= 3; n++) begin
      wr_reg(REG_RESOLUTION, 32'(n));
      wr_reg(REG_LEVEL, 32'h1);
      meas(hi, per);
      meas(hi, per);
      ep = int'(((32'h1 << n) * CLOCK_HZ) / BASE_TICK_HZ);
      `CHK("period", 1'b1, per >= ep - 1 && per <= ep + 1)
      ep = int'(CLOCK_HZ / BASE_TICK_HZ);
      `CHK("high", 1'b1, hi >= ep && hi <= ep + 1)
    end
    wr_reg(REG_LEVEL, 32'h0);
    repeat (800) @(posedge clock);
    count_hi(400, hi);
    `CHK("level zero", 0, hi)
    wr_reg(REG_RESOLUTION, 32'h5);
    wr_reg(REG_LEVEL, 32'h10);
    meas(hi, per);
    meas(hi, per);
    ep = int'((32'h20 * CLOCK_HZ) / BASE_TICK_HZ);
    `CHK("period 5", 1'b1, per >= ep - 1 && per <= ep + 1)
    ep = int'((32'h10 * CLOCK_HZ) / BASE_TICK_HZ);
    `CHK("high 5", 1'b1, hi >= ep - 1 && hi <= ep + 1)
    chk_rd("period end", REG_STATUS, 32'h4, 32'h4);
    wr_reg(REG_RESOLUTION, 32'h1);
    wr_reg(REG_LEVEL, 32'h1);
    chk_rd("level run", REG_LEVEL, 32'hffffffff, 32'h1);
    @(posedge analog_out);
    repeat (20) @(posedge clock);
    wr_reg(REG_FUNCTION, 32'h1);
    repeat (2) @(posedge clock);
    count_hi(200, hi);
    `CHK("disabled", 0, hi)
    chk_rd("count idle", REG_COUNT, 32'hffffffff, 32'h0);
    chk_rd("state off", REG_STATE, 32'h7, 32'h4);
    rd_reg(REG_PERIODS, v);
    `CHK("periods run", 1'b1, v != 32'h0)
    repeat (100) @(posedge clock);
    chk_rd("periods held", REG_PERIODS, 32'hffffffff, v);
    end_sim();
  end
endmodule
`default_nettype wire
